// *** include/uart_console_pkg.sv ***
// Constants for the UART console block: register map, reset values, field positions.
// Assumes a 32-bit AXI4-Lite register bus; printed offsets are word indexes.
package uart_console_pkg;
    // Printed offsets step by one, not by four: they are register indexes
    localparam logic [15:0] CFG_INDEX = 16'hf680;
    localparam logic [15:0] INT_DIV_INDEX = 16'hf681;
    localparam logic [15:0] FRAC_DIV_INDEX = 16'hf682;
    localparam logic [15:0] PROMPT_INDEX = 16'hf683;
    localparam logic [15:0] ERR_COUNT_INDEX = 16'hf684;
    localparam int ADDR_W = 18;
    localparam logic [15:0] CFG_RESET = 16'h0001;
    localparam logic [15:0] INT_DIV_RESET = 16'h0b71;
    localparam logic [7:0] FRAC_DIV_RESET = 8'hb0;
    localparam logic [15:0] PROMPT_RESET = 16'h003e;
    localparam logic [15:0] ERR_COUNT_RESET = 16'h0000;
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_PAREN_BIT = 1;
    localparam int CFG_STOP_LSB = 4;
    localparam int CFG_CR_OFF_BIT = 8;
    localparam int CFG_LF_OFF_BIT = 9;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h03f3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_LF = 8'h0a;
endpackage

// *** sim/serial_terminal.sv ***
// Serial terminal model: sends 8N1 characters, collects what the console sends.
// Assumes a bit lasts bit_len cycles of aclk, BIT until the bench sets it; the line idles high between frames.
`timescale 1ns/10ps
module serial_terminal #(parameter int BIT = 16)
(
    input wire logic aclk,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got[$];
    int stops = 1;
    int bad_stop = 0;
    int bit_len = BIT;
    initial rxd = 1'b1;
    task automatic send_bit(input logic b);
        repeat (bit_len) @(posedge aclk) rxd <= b;
    endtask
    // A broken stop bit is only sent when a scenario asks for one
    task automatic send_char(input logic [7:0] ch, input logic good_stop);
        send_bit(1'b0);
        for (int i = 0; i < 8; i++) send_bit(ch[i]);
        send_bit(good_stop);
        send_bit(1'b1);
    endtask
    always
    begin : rx
        logic [7:0] ch;
        @(negedge txd);
        repeat (bit_len / 2) @(posedge aclk);
        if (txd === 1'b0)
        begin
            for (int i = 0; i < 8; i++)
            begin
                repeat (bit_len) @(posedge aclk);
                ch[i] = txd;
            end
            for (int s = 0; s < stops; s++)
            begin
                repeat (bit_len) @(posedge aclk);
                if (txd !== 1'b1) bad_stop++;
            end
            got.push_back(ch);
        end
    end
endmodule

// *** sim/uart_console_monitor.sv ***
// Checker for the console's bus handshakes, reset state and enter pulse.
// Assumes it is bound to uart_console and sees only its ports.
`timescale 1ns/10ps
module uart_console_monitor
    import uart_console_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic txd,
    input wire logic enter_seen
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_read_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_read_answer; s_axi_rvalid ##0 !s_axi_arready; endsequence
    property p_read_answer; s_read_taken |=> s_read_answer; endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered one cycle after address");
    property p_read_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data dropped or changed before rready");
    property p_write_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");
    property p_write_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("write response dropped before bready");
    property p_ar_ready; s_axi_arready == !s_axi_rvalid; endproperty
    a_ar_ready: assert property (p_ar_ready)
        else $error("arready not the inverse of rvalid");
    property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data above bit 15 not zero");
    property p_slverr_zero;
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_slverr_zero: assert property (p_slverr_zero)
        else $error("refused read returned data");
    property p_enter_pulse; enter_seen |=> !enter_seen; endproperty
    a_enter_pulse: assert property (p_enter_pulse)
        else $error("enter pulse longer than one cycle");
    property p_reset_idle;
        $rose(aresetn) |-> txd && s_axi_awready && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");
endmodule
bind uart_console uart_console_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd(txd),
    .enter_seen(enter_seen));

// *** sim/uart_console_tb.sv ***
// Self-checking bench for uart_console over AXI4-Lite and the serial lines.
// Assumes a 16-cycle bit once the divider is set to 0x0010.
`timescale 1ns/10ps
module uart_console_tb import uart_console_pkg::*;;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rxd, txd, enter_seen;
    int error_cnt = 0, checked = 0, enter_cnt = 0, cycles = 0;
    always #50 aclk = ~aclk;
    uart_console uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rxd(rxd), .txd(txd), .enter_seen(enter_seen));
    serial_terminal #(.BIT(16)) term (.aclk(aclk), .txd(txd), .rxd(rxd));
    always @(posedge aclk)
    begin
        if (enter_seen === 1'b1) enter_cnt++;
        cycles++;
        // Whole run needs about 7000 cycles
        if (cycles == 40000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("Counts: %0d errors in %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        checked++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
    endtask
    // Sends one character, waits for k replies, then compares replies and enter pulses
    task automatic talk(input logic [7:0] ch, input int k, input int en, input logic [15:0] p);
        int n;
        term.got.delete();
        enter_cnt = 0;
        term.send_char(ch, 1'b1);
        for (n = 0; n < 1000 && term.got.size() < (k > 0 ? k : 1); n++) @(posedge aclk);
        check(term.got.size(), k);
        check(enter_cnt, en);
        if (k > 0) check(term.got[0], p[7:0]);
        if (k > 1) check(term.got[1], p[15:8]);
    endtask
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CFG_INDEX, 32'h0001, RESP_OKAY);
        rd(INT_DIV_INDEX, 32'h0b71, RESP_OKAY);
        rd(FRAC_DIV_INDEX, 32'h00b0, RESP_OKAY);
        rd(PROMPT_INDEX, 32'h003e, RESP_OKAY);
        rd(ERR_COUNT_INDEX, 32'h0000, RESP_OKAY);
        // Stop the slow reset-rate prompt before speeding the bit clock up
        wr(CFG_INDEX, 32'h0000, RESP_OKAY);
        wr(INT_DIV_INDEX, 32'h0010, RESP_OKAY);
        wr(FRAC_DIV_INDEX, 32'h1234, RESP_OKAY);
        rd(FRAC_DIV_INDEX, 32'h0034, RESP_OKAY);
        wr(FRAC_DIV_INDEX, 32'h0000, RESP_OKAY);
        wr(CFG_INDEX, 32'h0001, RESP_OKAY);
        repeat (400) @(posedge aclk);
        talk(CHAR_CR, 1, 1, 16'h003e);
        wr(PROMPT_INDEX, 32'h2141, RESP_OKAY);
        wr(CFG_INDEX, 32'h0011, RESP_OKAY);
        term.stops = 2;
        talk(CHAR_LF, 2, 1, 16'h2141);
        check(term.bad_stop, 0);
        wr(PROMPT_INDEX, 32'h0041, RESP_OKAY);
        talk(CHAR_CR, 1, 1, 16'h0041);
        wr(INT_DIV_INDEX, 32'h0018, RESP_OKAY);
        term.bit_len = 24;
        talk(CHAR_CR, 1, 1, 16'h0041);
        wr(CFG_INDEX, 32'h0111, RESP_OKAY);
        talk(CHAR_CR, 0, 0, 16'h0000);
        talk(CHAR_LF, 1, 1, 16'h0041);
        wr(CFG_INDEX, 32'h0211, RESP_OKAY);
        talk(CHAR_LF, 0, 0, 16'h0000);
        term.send_char(8'h55, 1'b0);
        rd(ERR_COUNT_INDEX, 32'h0001, RESP_OKAY);
        wr(ERR_COUNT_INDEX, 32'h0000, RESP_OKAY);
        rd(ERR_COUNT_INDEX, 32'h0001, RESP_OKAY);
        wr(16'hf685, 32'h0001, RESP_SLVERR);
        rd(16'hf685, 32'h0000, RESP_SLVERR);
        wr(CFG_INDEX, 32'h0000, RESP_OKAY);
        talk(CHAR_CR, 0, 0, 16'h0000);
        conclude();
    end
endmodule

// *** verilog/uart_bit_timer.sv ***
// Fractional divider timer: one tick per int_divider + frac_divider/256 cycles.
// Assumes the reference clock is the aclk of the surrounding block.
`timescale 1ns/10ps
module uart_bit_timer
    import uart_console_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [15:0] int_divider,
    input wire logic [7:0] frac_divider,
    output logic tick
);
    logic [16:0] count_reg;
    logic [16:0] count_next;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic tick_reg;
    logic tick_next;
    logic [8:0] sum;
    logic [16:0] period;

    always_comb
    begin
        sum = {1'b0, acc_reg} + {1'b0, frac_divider};
        // Overflow of the accumulator stretches this period by one cycle
        period = {1'b0, int_divider} + {16'h0000, sum[8]};
        count_next = count_reg;
        acc_next = acc_reg;
        tick_next = 1'b0;
        if (!run)
        begin
            count_next = 17'h00001;
            acc_next = 8'h00;
        end
        else if (count_reg >= period)
        begin
            count_next = 17'h00001;
            acc_next = sum[7:0];
            tick_next = 1'b1;
        end
        else
        begin
            count_next = count_reg + 17'h00001;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_reg <= 17'h00001;
            acc_reg <= 8'h00;
            tick_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            acc_reg <= acc_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// *** verilog/uart_console.sv ***
// UART console: baud generation, prompt output, receive error tally, AXI4-Lite registers.
// Assumes aclk is the bit-timing reference; rxd arrives from a pin, asynchronously.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module uart_console
    import uart_console_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxd,
    output logic txd,
    output logic enter_seen
);
    typedef enum {TX_IDLE, TX_START, TX_BITS, TX_PAR, TX_STOP} tx_state_t;

    // Register state
    logic [15:0] cfg_reg, cfg_next;
    logic [15:0] int_div_reg, int_div_next;
    logic [7:0] frac_div_reg, frac_div_next;
    logic [15:0] prompt_reg, prompt_next;
    logic [15:0] err_count_reg, err_count_next;
    logic aw_got_reg, aw_got_next;
    logic w_got_reg, w_got_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // Link state
    logic rx_meta_reg, rx_sync_reg;
    tx_state_t tx_state_reg, tx_state_next;
    logic [3:0] tx_sub_reg, tx_sub_next;
    logic [3:0] tx_idx_reg, tx_idx_next;
    logic [7:0] tx_shift_reg, tx_shift_next;
    logic tx_par_reg, tx_par_next;
    logic txd_reg, txd_next;
    logic prompt_second_reg, prompt_second_next;
    logic prompt_due_reg, prompt_due_next;
    logic enter_reg, enter_next;

    logic run;
    logic tick16;
    logic [7:0] rx_data;
    logic rx_done;
    logic rx_error;
    logic [15:0] wr_index;
    logic [15:0] rd_index;
    logic wr_fire;

    assign run = cfg_reg[CFG_EN_BIT];
    assign wr_index = 16'(awaddr_reg >> 2);
    assign rd_index = 16'(s_axi_araddr >> 2);
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

    // Divider counts one sixteenth of a bit so the receiver can oversample
    uart_bit_timer timer_u (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .int_divider(int_div_reg >> 4),
        .frac_divider({int_div_reg[3:0], frac_div_reg[7:4]}),
        .tick(tick16)
    );

    uart_serial_rx rx_u (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .parity_on(cfg_reg[CFG_PAREN_BIT]),
        .tick16(tick16),
        .rxd(rx_sync_reg),
        .data(rx_data),
        .done(rx_done),
        .error(rx_error)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0])
            r[7:0] = d[7:0];
        if (strb[1])
            r[15:8] = d[15:8];
        return r;
    endfunction

    // Register bus
    always_comb
    begin
        cfg_next = cfg_reg;
        int_div_next = int_div_reg;
        frac_div_next = frac_div_reg;
        prompt_next = prompt_reg;
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && !aw_got_reg)
        begin
            aw_got_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_reg)
        begin
            w_got_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            unique case (wr_index)
                CFG_INDEX:
                    cfg_next = merge16(cfg_reg, wdata_reg, wstrb_reg) & CFG_WRITE_MASK;
                INT_DIV_INDEX: int_div_next = merge16(int_div_reg, wdata_reg, wstrb_reg);
                FRAC_DIV_INDEX:
                    if (wstrb_reg[0])
                        frac_div_next = wdata_reg[7:0];
                PROMPT_INDEX: prompt_next = merge16(prompt_reg, wdata_reg, wstrb_reg);
                ERR_COUNT_INDEX: bresp_next = RESP_OKAY; // Read only, write ignored
                default: bresp_next = RESP_SLVERR;
            endcase
        end
        else if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
        if (s_axi_arvalid && !rvalid_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            unique case (rd_index)
                CFG_INDEX: rdata_next = {16'h0000, cfg_reg};
                INT_DIV_INDEX: rdata_next = {16'h0000, int_div_reg};
                FRAC_DIV_INDEX: rdata_next = {24'h000000, frac_div_reg};
                PROMPT_INDEX: rdata_next = {16'h0000, prompt_reg};
                ERR_COUNT_INDEX: rdata_next = {16'h0000, err_count_reg};
                default:
                begin
                    rdata_next = 32'h00000000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
    end

    // Serial side
    always_comb
    begin
        tx_state_next = tx_state_reg;
        tx_sub_next = tx_sub_reg;
        tx_idx_next = tx_idx_reg;
        tx_shift_next = tx_shift_reg;
        tx_par_next = tx_par_reg;
        txd_next = txd_reg;
        prompt_second_next = prompt_second_reg;
        prompt_due_next = prompt_due_reg;
        enter_next = 1'b0;
        err_count_next = err_count_reg;
        if (rx_error)
            err_count_next = err_count_reg + 16'h0001;
        // Enter from the terminal asks for a fresh prompt
        if (rx_done && ((rx_data == CHAR_CR && !cfg_reg[CFG_CR_OFF_BIT])
                        || (rx_data == CHAR_LF && !cfg_reg[CFG_LF_OFF_BIT])))
        begin
            enter_next = 1'b1;
            prompt_due_next = 1'b1;
        end
        if (!run)
        begin
            tx_state_next = TX_IDLE;
            txd_next = 1'b1;
            prompt_second_next = 1'b0;
            prompt_due_next = 1'b0;
        end
        else if (tick16)
        begin
            tx_sub_next = tx_sub_reg + 4'h1;
            unique case (tx_state_reg)
                TX_IDLE:
                    if (prompt_due_reg || prompt_second_reg)
                    begin
                        tx_shift_next = prompt_second_reg ? prompt_reg[15:8] : prompt_reg[7:0];
                        prompt_second_next = !prompt_second_reg && (prompt_reg[15:8] != 8'h00);
                        prompt_due_next = enter_next;
                        tx_par_next = 1'b0;
                        tx_sub_next = 4'h0;
                        tx_state_next = TX_START;
                        txd_next = 1'b0;
                    end
                TX_START:
                    if (tx_sub_reg == 4'hf)
                    begin
                        tx_idx_next = 4'h0;
                        txd_next = tx_shift_reg[0];
                        tx_state_next = TX_BITS;
                    end
                TX_BITS:
                    if (tx_sub_reg == 4'hf)
                    begin
                        tx_par_next = tx_par_reg ^ tx_shift_reg[0];
                        tx_shift_next = {1'b0, tx_shift_reg[7:1]};
                        tx_idx_next = tx_idx_reg + 4'h1;
                        txd_next = tx_shift_reg[1];
                        if (tx_idx_reg == 4'h7)
                        begin
                            tx_idx_next = 4'h0;
                            tx_state_next = cfg_reg[CFG_PAREN_BIT] ? TX_PAR : TX_STOP;
                            txd_next = cfg_reg[CFG_PAREN_BIT] ? (tx_par_reg ^ tx_shift_reg[0])
                                                              : 1'b1;
                        end
                    end
                TX_PAR:
                    if (tx_sub_reg == 4'hf)
                    begin
                        tx_state_next = TX_STOP;
                        txd_next = 1'b1;
                    end
                TX_STOP:
                    if (tx_sub_reg == 4'hf)
                    begin
                        tx_idx_next = tx_idx_reg + 4'h1;
                        // One stop bit plus the extra count
                        if (tx_idx_reg == cfg_reg[CFG_STOP_LSB +: 4])
                            tx_state_next = TX_IDLE;
                    end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_reg <= CFG_RESET;
            int_div_reg <= INT_DIV_RESET;
            frac_div_reg <= FRAC_DIV_RESET;
            prompt_reg <= PROMPT_RESET;
            err_count_reg <= ERR_COUNT_RESET;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            tx_state_reg <= TX_IDLE;
            tx_sub_reg <= 4'h0;
            tx_idx_reg <= 4'h0;
            tx_shift_reg <= 8'h00;
            tx_par_reg <= 1'b0;
            txd_reg <= 1'b1;
            prompt_second_reg <= 1'b0;
            prompt_due_reg <= 1'b1;
            enter_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            int_div_reg <= int_div_next;
            frac_div_reg <= frac_div_next;
            prompt_reg <= prompt_next;
            err_count_reg <= err_count_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            rx_meta_reg <= rxd;
            rx_sync_reg <= rx_meta_reg;
            tx_state_reg <= tx_state_next;
            tx_sub_reg <= tx_sub_next;
            tx_idx_reg <= tx_idx_next;
            tx_shift_reg <= tx_shift_next;
            tx_par_reg <= tx_par_next;
            txd_reg <= txd_next;
            prompt_second_reg <= prompt_second_next;
            prompt_due_reg <= prompt_due_next;
            enter_reg <= enter_next;
        end
    end

    assign s_axi_awready = !aw_got_reg;
    assign s_axi_wready = !w_got_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign txd = txd_reg;
    assign enter_seen = enter_reg;
endmodule

// *** verilog/uart_serial_rx.sv ***
// Serial receiver: 8N1 frames with optional even parity, 16x oversampled.
// Assumes rxd is already synchronised and tick16 is one pulse per 1/16 bit.
`timescale 1ns/10ps
module uart_serial_rx
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic parity_on,
    input wire logic tick16,
    input wire logic rxd,
    output logic [7:0] data,
    output logic done,
    output logic error
);
    typedef enum {RX_IDLE, RX_START, RX_BITS, RX_PAR, RX_STOP} rx_state_t;
    rx_state_t state_reg, state_next;
    logic [3:0] sub_reg, sub_next;
    logic [2:0] idx_reg, idx_next;
    logic [7:0] data_reg, data_next;
    logic par_reg, par_next;
    logic done_reg, done_next;
    logic err_reg, err_next;

    always_comb
    begin
        state_next = state_reg;
        sub_next = sub_reg;
        idx_next = idx_reg;
        data_next = data_reg;
        par_next = par_reg;
        done_next = 1'b0;
        err_next = 1'b0;
        if (!run)
            state_next = RX_IDLE;
        else if (tick16)
        begin
            sub_next = sub_reg + 4'h1;
            unique case (state_reg)
                RX_IDLE:
                    if (!rxd)
                    begin
                        state_next = RX_START;
                        sub_next = 4'h1;
                    end
                RX_START:
                    if (sub_reg == 4'h7)
                    begin
                        sub_next = 4'h0;
                        idx_next = 3'h0;
                        par_next = 1'b0;
                        state_next = rxd ? RX_IDLE : RX_BITS;
                    end
                RX_BITS:
                    if (sub_reg == 4'hf)
                    begin
                        data_next = {rxd, data_reg[7:1]};
                        par_next = par_reg ^ (rxd & parity_on);
                        idx_next = idx_reg + 3'h1;
                        if (idx_reg == 3'h7)
                            state_next = parity_on ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    if (sub_reg == 4'hf)
                    begin
                        par_next = par_reg ^ rxd;
                        state_next = RX_STOP;
                    end
                RX_STOP:
                    if (sub_reg == 4'hf)
                    begin
                        state_next = RX_IDLE;
                        done_next = rxd & ~par_reg;
                        err_next = ~rxd | par_reg;
                    end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= RX_IDLE;
            sub_reg <= 4'h0;
            idx_reg <= 3'h0;
            data_reg <= 8'h00;
            par_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            sub_reg <= sub_next;
            idx_reg <= idx_next;
            data_reg <= data_next;
            par_reg <= par_next;
            done_reg <= done_next;
            err_reg <= err_next;
        end
    end

    assign data = data_reg;
    assign done = done_reg;
    assign error = err_reg;
endmodule
